/* File: twm_pkg.sv */
/*
 * Shared constants and types of the two-wire bus master: register
 * offsets, control bit positions, status codes, timing counts, the
 * state enumeration and the packed state records.
 * Assumes a 20 MHz system clock and byte-addressed Wishbone offsets.
 */
`default_nettype none
package twm_pkg;
   // System clock period in ns
   localparam int unsigned CLK_NS   = 50;
   // Serial bit period in ns (standard rate)
   localparam int unsigned BIT_NS   = 10000;
   // Quarter bit in system clocks, rounded down, at least one
   localparam int unsigned QTR_RAW  = BIT_NS / (4 * CLK_NS);
   localparam int unsigned QTR_CYC  = (QTR_RAW < 1) ? 1 : QTR_RAW;
   // Longest spike that the pin filter swallows, ns and clocks
   localparam int unsigned SPIKE_NS = 50;
   localparam int unsigned SPK_RAW  = SPIKE_NS / CLK_NS;
   localparam int unsigned SPIKE_CYC = (SPK_RAW < 1) ? 1 : SPK_RAW;

   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_DATA = 8'h08;
   localparam logic [7:0] A_IST  = 8'h0C;
   localparam logic [7:0] A_IMSK = 8'h10;

   // Control register bit positions
   localparam int B_EVT  = 7;
   localparam int B_ACK  = 6;
   localparam int B_STA  = 5;
   localparam int B_STO  = 4;
   localparam int B_WCOL = 3;
   localparam int B_EN   = 2;
   localparam int B_IE   = 0;

   // Interrupt status bit positions
   localparam int I_EVT  = 0;
   localparam int I_WCOL = 1;
   localparam int I_ARB  = 2;

   // Status codes shown in the status register
   localparam logic [7:0] C_START   = 8'h08;
   localparam logic [7:0] C_RSTART  = 8'h10;
   localparam logic [7:0] C_AW_ACK  = 8'h18;
   localparam logic [7:0] C_AW_NACK = 8'h20;
   localparam logic [7:0] C_TX_ACK  = 8'h28;
   localparam logic [7:0] C_TX_NACK = 8'h30;
   localparam logic [7:0] C_ARB     = 8'h38;
   localparam logic [7:0] C_AR_ACK  = 8'h40;
   localparam logic [7:0] C_AR_NACK = 8'h48;
   localparam logic [7:0] C_RX_ACK  = 8'h50;
   localparam logic [7:0] C_RX_NACK = 8'h58;
   localparam logic [7:0] C_IDLE    = 8'hF8;

   // Bit index of the acknowledge slot in a byte
   localparam logic [3:0] ACK_BIT = 4'h8;

   // Bus sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_FREE, ST_START, ST_WAIT, ST_BIT, ST_STOP, ST_RSTART
   } twm_state_e;

   // Whole state of the master
   typedef struct packed {
      twm_state_e  st;      // Sequencer state
      logic [1:0]  ph;      // Quarter-bit phase
      logic [15:0] qc;      // Quarter-bit timer
      logic [3:0]  bitn;    // Bit index in byte, 8 is ack
      logic [7:0]  sh;      // Shift register
      logic        rd;      // Read direction latched
      logic        adr;     // Next byte is the address byte
      logic        nak;     // Sampled or sent ack level
      logic        busy;    // Bus owned by someone
      logic        sda_p;   // Filtered data, last cycle
      logic        scl_p;   // Filtered clock, last cycle
      logic        evt;     // Bus event flag
      logic        ack_en;  // Ack enable
      logic        sta;     // Start request
      logic        sto;     // Stop request
      logic        wcol;    // Write collision flag
      logic        en;      // Interface enable
      logic        ie;      // Event interrupt enable
      logic [7:0]  code;    // Status code
      logic [7:0]  data;    // Data register
      logic [2:0]  ist;     // Interrupt status
      logic [2:0]  imsk;    // Interrupt mask
      logic        wb_ack;  // Bus acknowledge
      logic [31:0] wb_dat;  // Bus read data
      logic        sda_rel; // Data pin released
      logic        scl_rel; // Clock pin released
      logic        irq;     // Interrupt line
   } twm_state_s;

   // Values after reset
   localparam twm_state_s RST_S = '{st: ST_IDLE, code: C_IDLE,
      sda_p: 1'b1, scl_p: 1'b1, sda_rel: 1'b1, scl_rel: 1'b1,
      default: '0};

   // Pin filter state
   typedef struct packed {
      logic       s0;  // First sync stage
      logic       s1;  // Second sync stage
      logic       lvl; // Filtered level
      logic [3:0] cnt; // Stability counter
   } twm_filt_s;

   // Filter resets to an idle high line
   localparam twm_filt_s FILT_RST = '{s0: 1'b1, s1: 1'b1, lvl: 1'b1,
      cnt: 4'h0};
endpackage
`default_nettype wire

/* File: twm_filt.sv */
/*
 * Pin input conditioner: two-stage synchroniser and a spike filter
 * that passes a new level only once it has stood long enough.
 * Assumes an asynchronous pin and the system clock.
 */
`timescale 1ns/10ps
`default_nettype none
module twm_filt #(
   parameter logic [3:0] FILT = 4'(twm_pkg::SPIKE_CYC)
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   output var  logic lvl_o
);
   twm_pkg::twm_filt_s q;  // Current state
   twm_pkg::twm_filt_s d;  // Next state

   // Sync chain, then accept a change only when it stays put
   always_comb begin
      d = q;
      d.s0 = pin_i;
      d.s1 = q.s0;
      if (q.s1 == q.lvl) begin
         // Line agrees with output, restart the count
         d.cnt = 4'h0;
      end else if (q.cnt == FILT) begin
         // Level outlived a spike, take it
         d.lvl = q.s1;
         d.cnt = 4'h0;
      end else begin
         d.cnt = q.cnt + 4'h1;
      end
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= twm_pkg::FILT_RST;
      end else begin
         q <= d;
      end
   end

   assign lvl_o = q.lvl;

   // A level change needs two unequal samples before it
   AST_SPIKE: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(q.lvl) |-> $past(q.s1) != $past(q.lvl) &&
      $past(q.s1, 2) != $past(q.lvl, 2))
      else $error("Filter passed a short spike");
endmodule
`default_nettype wire

/* File: twm_master.sv */
/*
 * Two-wire bus master with a Wishbone register port: START, repeated
 * START, STOP, address and data bytes in both directions, status
 * codes, event flag, write collision and a masked interrupt.
 * Assumes open-drain pads outside and a 20 MHz system clock.
 */
// Decided for this implementation: the register offsets and register access over Wishbone.
// How it works
// - Start request waits for free bus, then START
// - START done sets event flag, code 08
// - Writing one to event flag resumes transfer
// - Address-write result gives code 18, 20, 38
// - Data write with flag low: discard, collision
// - One event per byte until stop/restart
// - Stop request drives a STOP condition
// - Start plus stop gives repeated START
// - Repeated START reports 10, any slave next
// - Received byte readable while event flag set
// - Enable takes data pin, open drain, slew
// - Enable takes clock pin for bus clock
// - Enabled pins drop spikes under 50 ns
`timescale 1ns/10ps
`default_nettype none
module twm_master #(
   parameter int          AW  = 8,
   parameter logic [15:0] QTR = 16'(twm_pkg::QTR_CYC)
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          cyc_i,
   input  wire logic          stb_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] adr_i,
   input  wire logic [3:0]    sel_i,
   input  wire logic [31:0]   dat_i,
   output var  logic [31:0]   dat_o,
   output var  logic          ack_o,
   output var  logic          irq_o,
   input  wire logic          sda_i,
   output var  logic          sda_o,
   output var  logic          sda_oe_n_o,
   input  wire logic          scl_i,
   output var  logic          scl_o,
   output var  logic          scl_oe_n_o,
   output var  logic          pin_own_o,
   output var  logic          slew_lim_o
);
   twm_pkg::twm_state_s q;  // Current state
   twm_pkg::twm_state_s d;  // Next state
   logic sda_f;             // Filtered data line
   logic scl_f;             // Filtered clock line
   logic req;               // New bus request this cycle
   logic wr;                // Low-byte write strobe
   logic tick;              // Quarter-bit timer expired
   logic adv;               // Phase may advance
   logic fin;               // Byte or condition done

   // Register select on word address
   function automatic logic hit(input logic [AW-1:0] a,
                                input logic [7:0] off);
      hit = (a[AW-1:2] == (AW-2)'(off[7:2]));
   endfunction

   // Control register image
   function automatic logic [7:0] ctrl_img(
      input twm_pkg::twm_state_s s);
      ctrl_img = {s.evt, s.ack_en, s.sta, s.sto, s.wcol, s.en, 1'b0,
                  s.ie};
   endfunction

   // Status code for a finished byte
   function automatic logic [7:0] byte_code(input logic a,
      input logic r, input logic n);
      if (a && !r) begin
         byte_code = n ? twm_pkg::C_AW_NACK : twm_pkg::C_AW_ACK;
      end else if (a) begin
         byte_code = n ? twm_pkg::C_AR_NACK : twm_pkg::C_AR_ACK;
      end else if (!r) begin
         byte_code = n ? twm_pkg::C_TX_NACK : twm_pkg::C_TX_ACK;
      end else begin
         byte_code = n ? twm_pkg::C_RX_NACK : twm_pkg::C_RX_ACK;
      end
   endfunction

   // Data line filter
   twm_filt u_sda (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pin_i (sda_i),
      .lvl_o (sda_f)
   );

   // Clock line filter
   twm_filt u_scl (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .pin_i (scl_i),
      .lvl_o (scl_f)
   );

   // Register port, bus watcher and the bit sequencer
   always_comb begin
      d = q;
      req  = cyc_i && stb_i && !q.wb_ack;
      wr   = req && we_i && sel_i[0];
      tick = (q.qc == 16'h0000);
      adv  = 1'b0;
      fin  = 1'b0;

      // One-cycle acknowledge for every request
      d.wb_ack = req;
      d.wb_dat = 32'h0000_0000;

      // Read mux; unmapped offsets read zero
      if (req && !we_i) begin
         if (hit(adr_i, twm_pkg::A_CTRL)) begin
            d.wb_dat[7:0] = ctrl_img(q);
         end else if (hit(adr_i, twm_pkg::A_STAT)) begin
            d.wb_dat[7:0] = q.code;
         end else if (hit(adr_i, twm_pkg::A_DATA)) begin
            d.wb_dat[7:0] = q.data;
         end else if (hit(adr_i, twm_pkg::A_IST)) begin
            d.wb_dat[2:0] = q.ist;
         end else if (hit(adr_i, twm_pkg::A_IMSK)) begin
            d.wb_dat[2:0] = q.imsk;
         end
      end

      // Register writes, before hardware sets so sets win
      if (wr && hit(adr_i, twm_pkg::A_CTRL)) begin
         // Writing one to the flag clears it
         if (dat_i[twm_pkg::B_EVT]) begin
            d.evt = 1'b0;
         end
         d.ack_en = dat_i[twm_pkg::B_ACK];
         d.sta    = dat_i[twm_pkg::B_STA];
         d.sto    = dat_i[twm_pkg::B_STO];
         d.en     = dat_i[twm_pkg::B_EN];
         d.ie     = dat_i[twm_pkg::B_IE];
      end
      if (wr && hit(adr_i, twm_pkg::A_DATA)) begin
         if (q.evt) begin
            // Legal load clears the collision flag
            d.data = dat_i[7:0];
            d.wcol = 1'b0;
         end else begin
            // Load outside an event is dropped
            d.wcol = 1'b1;
            d.ist[twm_pkg::I_WCOL] = 1'b1;
         end
      end
      if (wr && hit(adr_i, twm_pkg::A_IST)) begin
         d.ist = d.ist & ~dat_i[2:0];
      end
      if (wr && hit(adr_i, twm_pkg::A_IMSK)) begin
         d.imsk = dat_i[2:0];
      end

      // Bus watcher: START and STOP seen on filtered lines
      d.sda_p = sda_f;
      d.scl_p = scl_f;
      if (scl_f && q.scl_p && q.sda_p && !sda_f) begin
         d.busy = 1'b1;
      end else if (scl_f && q.scl_p && !q.sda_p && sda_f) begin
         d.busy = 1'b0;
      end

      // Quarter-bit timer runs in the timed states
      if (q.st inside {twm_pkg::ST_START, twm_pkg::ST_BIT,
                       twm_pkg::ST_STOP, twm_pkg::ST_RSTART}) begin
         // Phase 2 with a released clock waits for it high
         adv = tick && !(q.ph == 2'd2 && q.st != twm_pkg::ST_START
                         && !scl_f);
         if (!tick) begin
            d.qc = q.qc - 16'h0001;
         end else if (adv) begin
            d.qc = QTR - 16'h0001;
            d.ph = q.ph + 2'd1;
         end
      end

      unique case (q.st)
         // Idle: a start request sends us looking for a free bus
         twm_pkg::ST_IDLE: begin
            if (q.en && q.sta && !q.evt) begin
               d.st = twm_pkg::ST_FREE;
            end
         end
         // Wait until nobody owns the bus and both lines are high
         twm_pkg::ST_FREE: begin
            if (!q.sta) begin
               d.st = twm_pkg::ST_IDLE;
            end else if (!q.busy && sda_f && scl_f) begin
               d.st = twm_pkg::ST_START;
               d.ph = 2'd0;
               d.qc = QTR - 16'h0001;
            end
         end
         // START: data low, then clock low, then report
         twm_pkg::ST_START: begin
            if (adv) begin
               unique case (q.ph)
                  2'd0: d.sda_rel = 1'b0;
                  2'd1: d.scl_rel = 1'b0;
                  default: begin
                     d.st   = twm_pkg::ST_WAIT;
                     d.code = twm_pkg::C_START;
                     d.adr  = 1'b1;
                     fin    = 1'b1;
                  end
               endcase
            end
         end
         // Clock held low until software clears the flag
         twm_pkg::ST_WAIT: begin
            if (!q.evt) begin
               d.ph = 2'd0;
               d.qc = QTR - 16'h0001;
               if (q.sta) begin
                  d.st = twm_pkg::ST_RSTART;
               end else if (q.sto) begin
                  d.st = twm_pkg::ST_STOP;
               end else begin
                  // Next byte; address bit 0 picks direction
                  d.st   = twm_pkg::ST_BIT;
                  d.bitn = 4'h0;
                  d.sh   = q.data;
                  if (q.adr) begin
                     d.rd = q.data[0];
                  end
               end
            end
         end
         // One bit per pass: set data, clock high, sample, clock low
         twm_pkg::ST_BIT: begin
            if (adv) begin
               unique case (q.ph)
                  2'd0: begin
                     if (q.bitn == twm_pkg::ACK_BIT) begin
                        // Receiver acks per ack enable
                        d.sda_rel = (q.rd && !q.adr) ? !q.ack_en
                                                     : 1'b1;
                     end else begin
                        d.sda_rel = (q.rd && !q.adr) ? 1'b1
                                                     : q.sh[7];
                     end
                  end
                  2'd1: d.scl_rel = 1'b1;
                  2'd2: begin
                     if (q.bitn == twm_pkg::ACK_BIT) begin
                        d.nak = sda_f;
                     end else if (q.sda_rel && !sda_f &&
                                  !(q.rd && !q.adr)) begin
                        // Lost arbitration: free the bus
                        d.st      = twm_pkg::ST_IDLE;
                        d.sda_rel = 1'b1;
                        d.code    = twm_pkg::C_ARB;
                        d.ist[twm_pkg::I_ARB] = 1'b1;
                        fin       = 1'b1;
                     end else begin
                        d.sh = {q.sh[6:0], sda_f};
                     end
                  end
                  default: begin
                     d.scl_rel = 1'b0;
                     if (q.bitn == twm_pkg::ACK_BIT) begin
                        // Byte done, one event per byte
                        d.st   = twm_pkg::ST_WAIT;
                        d.adr  = 1'b0;
                        d.code = byte_code(q.adr, q.rd, q.nak);
                        fin    = 1'b1;
                        if (q.rd && !q.adr) begin
                           d.data = q.sh;
                        end
                     end else begin
                        d.bitn = q.bitn + 4'h1;
                     end
                  end
               endcase
            end
         end
         // STOP: data low, clock high, data high
         twm_pkg::ST_STOP: begin
            if (adv) begin
               unique case (q.ph)
                  2'd0: d.sda_rel = 1'b0;
                  2'd1: d.scl_rel = 1'b1;
                  2'd2: d.sda_rel = 1'b1;
                  default: begin
                     d.st   = twm_pkg::ST_IDLE;
                     d.sto  = 1'b0;
                     d.code = twm_pkg::C_IDLE;
                  end
               endcase
            end
         end
         // Repeated START from a held-low clock
         twm_pkg::ST_RSTART: begin
            if (adv) begin
               unique case (q.ph)
                  2'd0: d.sda_rel = 1'b1;
                  2'd1: d.scl_rel = 1'b1;
                  2'd2: d.sda_rel = 1'b0;
                  default: begin
                     d.scl_rel = 1'b0;
                     d.st   = twm_pkg::ST_WAIT;
                     d.sto  = 1'b0;
                     d.adr  = 1'b1;
                     d.code = twm_pkg::C_RSTART;
                     fin    = 1'b1;
                  end
               endcase
            end
         end
      endcase

      // Hardware sets the event flag last so it beats a clear
      if (fin) begin
         d.evt = 1'b1;
         if (q.ie) begin
            d.ist[twm_pkg::I_EVT] = 1'b1;
         end
      end

      // Disabled: let go of both pins and stop the sequencer
      if (!d.en) begin
         d.st      = twm_pkg::ST_IDLE;
         d.sda_rel = 1'b1;
         d.scl_rel = 1'b1;
      end

      d.irq = |(d.ist & d.imsk);
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= twm_pkg::RST_S;
      end else begin
         q <= d;
      end
   end

   // Pads only ever pull low; enable low means driving
   assign sda_o      = 1'b0;
   assign scl_o      = 1'b0;
   assign sda_oe_n_o = q.sda_rel;
   assign scl_oe_n_o = q.scl_rel;
   assign pin_own_o  = q.en;
   assign slew_lim_o = q.en;
   assign dat_o      = q.wb_dat;
   assign ack_o      = q.wb_ack;
   assign irq_o      = q.irq;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_FREE_START: assert property (
      q.st == twm_pkg::ST_START && $past(q.st) == twm_pkg::ST_FREE
      |-> $past(!q.busy && sda_f && scl_f))
      else $error("START issued on a busy bus");
   AST_START_08: assert property (
      $past(q.st) == twm_pkg::ST_START && q.st == twm_pkg::ST_WAIT
      |-> q.evt && q.code == twm_pkg::C_START)
      else $error("START done without flag and code 08");
   AST_HOLD: assert property (
      q.st == twm_pkg::ST_WAIT && q.evt |=> q.st == twm_pkg::ST_WAIT)
      else $error("Transfer resumed with flag set");
   AST_ADDR_W: assert property (
      $rose(q.evt) && $past(q.adr && !q.rd && q.st == twm_pkg::ST_BIT)
      |-> q.code inside {8'h18, 8'h20, 8'h38})
      else $error("Bad code after address-write byte");
   AST_WCOL: assert property (
      req && we_i && sel_i[0] && hit(adr_i, twm_pkg::A_DATA) && !q.evt
      |=> q.wcol && $stable(q.data))
      else $error("Collision write not discarded");
   AST_STOP: assert property (
      q.st == twm_pkg::ST_WAIT && !q.evt && q.sto && !q.sta && q.en
      |=> q.st == twm_pkg::ST_STOP)
      else $error("Stop request ignored");
   AST_RSTART_10: assert property (
      $past(q.st) == twm_pkg::ST_RSTART && q.st == twm_pkg::ST_WAIT
      |-> q.code == twm_pkg::C_RSTART && q.adr)
      else $error("Repeated START not reported as 10");
   AST_ADDR_R: assert property (
      $rose(q.evt) && $past(q.adr && q.rd && q.st == twm_pkg::ST_BIT)
      |-> q.code inside {8'h40, 8'h48, 8'h38})
      else $error("Bad code after address-read byte");
   AST_PINS_OFF: assert property (
      !q.en |-> sda_oe_n_o && scl_oe_n_o && !pin_own_o)
      else $error("Pins driven while disabled");

   COV_START: cover property (q.code == twm_pkg::C_START && q.evt);
   COV_RX: cover property (q.code == twm_pkg::C_RX_ACK && q.evt);
   COV_RS: cover property (q.code == twm_pkg::C_RSTART && q.evt);
   COV_ARB: cover property (q.code == twm_pkg::C_ARB && q.evt);
endmodule
`default_nettype wire

/* File: twm_slave.sv */
/*
 * Behavioural slave on the two-wire bus: acks its own address,
 * takes written bytes, returns one byte for reads.
 * Assumes pulled-up wired-and lines built by the bench.
 */
`timescale 1ns/10ps
`default_nettype none
module twm_slave #(
   parameter logic [6:0] ADDR = 7'h5A
) (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic [7:0] tx_i,
   output var  logic       sda_oe_n_o,
   output var  logic [7:0] rx_o,
   output var  logic [3:0] stops_o
);
   int         n;   // Rising clock edges in this byte
   logic [7:0] sh;  // Incoming shift register
   logic       sel; // Addressed by the last START
   logic       rd;  // Read direction
   logic       adr; // Next byte is the address
   logic       act; // A START has been seen, so a STOP may follow
   initial begin
      sda_oe_n_o = 1'b1;
      stops_o = 4'h0;
      act = 1'b0;
      {n, sel, rd, adr} = '0;
   end
   // START or repeated START: expect an address
   always @(negedge sda) if (scl === 1'b1) begin
      n = 0;
      adr = 1'b1;
      sel = 1'b0;
      act = 1'b1;
   end
   // STOP: deselect; lines settling out of reset are not a STOP
   always @(posedge sda) if (scl === 1'b1 && act) begin
      act = 1'b0;
      sel = 1'b0;
      stops_o = stops_o + 4'h1;
   end
   // Sample on the rising clock, MSB first
   always @(posedge scl) begin
      sh = {sh[6:0], sda};
      n = n + 1;
   end
   // Drive ack or read data while the clock is low
   always @(negedge scl) begin
      if (n == 8) begin
         if (adr) begin
            sel = (sh[7:1] == ADDR);
            rd = sh[0];
            adr = 1'b0;
            sda_oe_n_o = !sel;
         end else begin
            if (sel && !rd) rx_o = sh;
            sda_oe_n_o = !(sel && !rd);
         end
      end else if (n == 9) begin
         // Ack slot over: count anew; a nack on a read ends our turn
         n = 0;
         if (sel && rd && sh[0]) sel = 1'b0;
         sda_oe_n_o = (sel && rd) ? tx_i[7] : 1'b1;
      end else if (n >= 1 && n <= 7 && sel && rd) begin
         sda_oe_n_o = tx_i[7-n];
      end else begin
         sda_oe_n_o = 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: two_wire_bus_master_test.sv */
/*
 * Self-checking bench for the two-wire master: registers over
 * Wishbone, write, read, restart, stop, collision and interrupt.
 * Assumes twm_master with a short quarter bit and twm_slave.
 */
`timescale 1ns/10ps
`default_nettype none
module two_wire_bus_master_test;
   logic        clk_i, rst_i, cyc, stb, we;
   logic [7:0]  adr, txb, db;
   logic [31:0] dat, dat_o, q;
   logic        ack, irq, sda_oe_n, scl_oe_n, s_oe_n, own, slew;
   logic [7:0]  rx;
   logic [3:0]  stops;
   wire         sda = sda_oe_n & s_oe_n; // Pulled-up wired-and
   wire         scl = scl_oe_n;
   int          error_cnt, tests_run;
   twm_master #(.QTR(16'd4)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
      .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .irq_o(irq),
      .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n), .scl_i(scl),
      .scl_o(), .scl_oe_n_o(scl_oe_n), .pin_own_o(own),
      .slew_lim_o(slew));
   twm_slave i_sl (.scl(scl), .sda(sda), .tx_i(txb),
      .sda_oe_n_o(s_oe_n), .rx_o(rx), .stops_o(stops));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic complete_run;
      if (error_cnt == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   // Poll a register until a masked bit shows up
   task automatic wt(input logic [7:0] a, input logic [7:0] m);
      for (int i = 0; i < 300; i++) begin
         wb(1'b0, a, 0);
         if ((q[7:0] & m) != 8'h00) break;
      end
   endtask
   task automatic ev(input logic [7:0] code);
      wt(8'h00, 8'h80);
      wb(1'b0, 8'h04, 0);
      chk(q[7:0], code);
   endtask
   // Load data, clear the event flag, check the next code
   task automatic xfer(input logic [7:0] d, input logic [7:0] c,
                       input logic [7:0] code);
      wb(1'b1, 8'h08, {24'h0, d});
      wb(1'b1, 8'h00, {24'h0, c});
      ev(code);
   endtask
   initial begin
      #2_000_000;
      error_cnt++;
      complete_run();
   end
   initial begin
      {cyc, stb, we, adr, dat, error_cnt, tests_run} = '0;
      rst_i = 1'b1;
      void'($urandom(81));
      txb = 8'($urandom);
      db = 8'($urandom);
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h04, 0); chk(q, 32'hF8);
      wb(1'b0, 8'h14, 0); chk(q, 0);
      wb(1'b1, 8'h08, 32'h11); wb(1'b0, 8'h00, 0);
      chk(q[3], 1);
      wb(1'b1, 8'h10, 2); repeat (2) @(posedge clk_i);
      chk(irq, 1);
      wb(1'b1, 8'h0C, 2); repeat (2) @(posedge clk_i);
      chk(irq, 0);
      wb(1'b1, 8'h00, 32'h24); ev(8'h08);
      chk({own, slew}, 2'b11);
      xfer(8'hB4, 8'h84, 8'h18);
      xfer(db, 8'h84, 8'h28); chk(rx, db);
      wb(1'b1, 8'h00, 32'hB4); ev(8'h10);
      xfer(8'hB5, 8'h84, 8'h40);
      xfer(8'h00, 8'h84, 8'h58);
      wb(1'b0, 8'h08, 0); chk(q[7:0], txb);
      wb(1'b1, 8'h00, 32'hA4); ev(8'h10);
      xfer(8'h40, 8'h84, 8'h20);
      wb(1'b1, 8'h00, 32'h94); wt(8'h04, 8'h80);
      chk(q[7:0], 8'hF8);
      chk({stops, sda, scl}, {4'h1, 2'b11});
      complete_run();
   end
endmodule
`default_nettype wire
